/* File: common/cra_pkg.sv */
/*
  Shared constants for the calendar counter: register offsets, field layout,
  reset values and calendar helper functions.
  Assumes a 32-bit APB register bus with byte addresses on an 8-bit paddr.
*/
`default_nettype none

package cra_pkg;

  localparam int unsigned CRA_AW = 8;
  localparam int unsigned CRA_DW = 32;

  // register byte offsets
  localparam logic [7:0] CRA_OFF_CONTROL_A = 8'h00;
  localparam logic [7:0] CRA_OFF_FLAGS = 8'h04;
  localparam logic [7:0] CRA_OFF_CLOCK = 8'h08;
  localparam logic [7:0] CRA_OFF_COMP0 = 8'h0C;
  localparam logic [7:0] CRA_OFF_COMP1 = 8'h10;
  localparam logic [7:0] CRA_OFF_ALARM = 8'h14;
  localparam logic [7:0] CRA_OFF_MASK = 8'h18;
  localparam logic [7:0] CRA_OFF_STAMP = 8'h1C;

  // control_a bit positions
  localparam int unsigned CRA_EN_BIT = 0;
  localparam int unsigned CRA_MODE_LSB = 2;
  localparam int unsigned CRA_HFMT_BIT = 6;
  localparam int unsigned CRA_MCLR_BIT = 7;

  // operating modes
  localparam logic [1:0] CRA_MODE_C32 = 2'h0;
  localparam logic [1:0] CRA_MODE_C16 = 2'h1;
  localparam logic [1:0] CRA_MODE_CAL = 2'h2;

  // interrupt_flags bit positions
  localparam int unsigned CRA_F_OVF = 0;
  localparam int unsigned CRA_F_ALM = 1;
  localparam int unsigned CRA_F_CMP0 = 2;
  localparam int unsigned CRA_F_CMP1 = 3;
  localparam int unsigned CRA_NFLAGS = 4;

  // time/date field positions
  localparam int unsigned CRA_MIN_LSB = 6;
  localparam int unsigned CRA_HOUR_LSB = 12;
  localparam int unsigned CRA_PM_BIT = 16;
  localparam int unsigned CRA_DAY_LSB = 17;
  localparam int unsigned CRA_MON_LSB = 22;
  localparam int unsigned CRA_YEAR_LSB = 26;

  localparam logic [5:0] CRA_SEC_MAX = 6'h3B;
  localparam logic [4:0] CRA_HOUR24_MAX = 5'h17;
  localparam logic [3:0] CRA_HOUR12_TOP = 4'hC;
  localparam logic [3:0] CRA_HOUR12_LAST = 4'hB;
  localparam logic [3:0] CRA_MON_MAX = 4'hC;
  localparam logic [5:0] CRA_YEAR_MAX = 6'h3F;

  localparam logic [31:0] CRA_RST_WORD = 32'h0000_0000;
  localparam logic [2:0] CRA_MASK_RST = 3'h0;
  localparam logic [1:0] CRA_SYNC_RST = 2'h3;

  // first instant of year 0: 00:00:00 (or 12 AM) on January 1
  function automatic logic [31:0] cra_cal_zero(input logic twelve);
    logic [31:0] v;
    v = 32'h0;
    v[CRA_DAY_LSB +: 5] = 5'h01;
    v[CRA_MON_LSB +: 4] = 4'h1;
    if (twelve) begin
      v[CRA_HOUR_LSB +: 4] = CRA_HOUR12_TOP;
    end
    return v;
  endfunction

  function automatic logic [4:0] cra_days_in_month(input logic [3:0] mon,
                                                   input logic [5:0] year);
    case (mon)
      4'h2: cra_days_in_month = (year[1:0] == 2'h0) ? 5'h1D : 5'h1C;
      4'h4, 4'h6, 4'h9, 4'hB: cra_days_in_month = 5'h1E;
      default: cra_days_in_month = 5'h1F;
    endcase
  endfunction

  // fields that take part in the alarm compare, counted from seconds up
  function automatic logic [31:0] cra_alarm_mask(input logic [2:0] sel);
    case (sel)
      3'h1: cra_alarm_mask = 32'h0000_003F;
      3'h2: cra_alarm_mask = 32'h0000_0FFF;
      3'h3: cra_alarm_mask = 32'h0001_FFFF;
      3'h4: cra_alarm_mask = 32'h003F_FFFF;
      3'h5: cra_alarm_mask = 32'h03FF_FFFF;
      3'h6: cra_alarm_mask = 32'hFFFF_FFFF;
      default: cra_alarm_mask = 32'h0000_0000;
    endcase
  endfunction

endpackage

`default_nettype wire

/* File: logic/cra_cal_step.sv */
/*
  One-second step of the packed time/date word, with carries through
  minutes, hours, days, months and the six-bit year.
  Assumes the current word holds a legal date; purely combinational.
*/
`timescale 1ns/10ps
`default_nettype none

module cra_cal_step
  import cra_pkg::*;
(
  input wire logic [31:0] cur_val,
  input wire logic twelve_hour,
  output logic [31:0] next_val,
  output logic wrapped
);

  wire logic [5:0] sec = cur_val[5:0];
  wire logic [5:0] min = cur_val[CRA_MIN_LSB +: 6];
  wire logic [4:0] hour = cur_val[CRA_HOUR_LSB +: 5];
  wire logic [3:0] h12 = cur_val[CRA_HOUR_LSB +: 4];
  wire logic pm = cur_val[CRA_PM_BIT];
  wire logic [4:0] day = cur_val[CRA_DAY_LSB +: 5];
  wire logic [3:0] mon = cur_val[CRA_MON_LSB +: 4];
  wire logic [5:0] year = cur_val[CRA_YEAR_LSB +: 6];

  wire logic sec_top = (sec == CRA_SEC_MAX);
  wire logic min_top = (min == CRA_SEC_MAX);
  wire logic hr_roll = sec_top & min_top;
  wire logic hour_top = twelve_hour ? (pm & (h12 == CRA_HOUR12_LAST))
                                    : (hour == CRA_HOUR24_MAX);
  wire logic day_roll = hr_roll & hour_top;
  wire logic day_top = (day == cra_days_in_month(mon, year));
  wire logic mon_roll = day_roll & day_top;
  wire logic yr_roll = mon_roll & (mon == CRA_MON_MAX);

  logic [4:0] hour_n;

  // 12-hour mode: 11 flips AM/PM into 12, 12 is followed by 1
  assign hour_n = !hr_roll ? hour :
                  !twelve_hour ? (hour_top ? 5'h00 : hour + 5'h01) :
                  (h12 == CRA_HOUR12_LAST) ? {~pm, CRA_HOUR12_TOP} :
                  (h12 == CRA_HOUR12_TOP) ? {pm, 4'h1} :
                  {pm, h12 + 4'h1};

  assign next_val[5:0] = sec_top ? 6'h00 : sec + 6'h01;
  assign next_val[CRA_MIN_LSB +: 6] = !sec_top ? min :
                                      min_top ? 6'h00 : min + 6'h01;
  assign next_val[CRA_HOUR_LSB +: 5] = hour_n;
  assign next_val[CRA_DAY_LSB +: 5] = !day_roll ? day :
                                      day_top ? 5'h01 : day + 5'h01;
  assign next_val[CRA_MON_LSB +: 4] = !mon_roll ? mon :
                                      (mon == CRA_MON_MAX) ? 4'h1 : mon + 4'h1;
  // six-bit year wraps 0x3F to 0x00 by itself
  assign next_val[CRA_YEAR_LSB +: 6] = yr_roll ? year + 6'h01 : year;
  assign wrapped = yr_roll & (year == CRA_YEAR_MAX);

endmodule

`default_nettype wire

/* File: logic/cra_rtc_core.sv */
/*
  Calendar / counter block with APB register access, maskable alarm,
  two 16-bit compares and a timestamp capture with its DMA request.
  Assumes counter_clock and timestamp_capture are asynchronous pins; pclk
  is much faster than either. APB slave with zero wait states.
*/
// The placing of the registers and the APB interface to the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - mode field value 0x2 turns the counter into a clock/calendar.
// - when enabled, calendar advances one second per counter clock rising edge.
// - time and date read and written as one 32-bit word.
// - hour format bit picks 12/24 hours; writable only while disabled.
// - day counts from 1; month 1 is January, 2 February.
// - year is 0x00..0x3F offset from a leap reference year.
// - after 23:59:59 Dec 31 year 0x3F wrap to start, set overflow.
// - alarm match sets alarm flag at the next counter clock rising edge.
// - alarm mask select chooses which fields take part in matching.
// - clear-on-match clears the counter on the cycle after an alarm match.
// - with clear-on-match, alarm and overflow flags set together.
// - 16-bit mode: count match with either compare sets its flag next edge.
// - timestamp capture raises tamper DMA request; timestamp read drops it.
module cra_rtc_core
  import cra_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [CRA_AW-1:0] paddr,
  input wire logic [CRA_DW-1:0] pwdata,
  output logic [CRA_DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic counter_clock,
  input wire logic timestamp_capture,
  output logic tamper_dma_req
);

  // pin synchronisers: bit 0 counter clock, bit 1 timestamp capture
  logic [1:0] s1_q, s2_q, s3_q, lvl_q;
  logic [1:0] lvl_d;
  logic [1:0] rise;
  logic [1:0] agree;

  // a level counts only once the second and third stages agree;
  // costs a cycle of latency but rejects a single-stage glitch
  assign agree = ~(s2_q ^ s3_q);
  assign lvl_d = (agree & s3_q) | (~agree & lvl_q);
  assign rise = lvl_d & ~lvl_q;

  // reset high: a pin already high at reset release is no edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= CRA_SYNC_RST;
      s2_q <= CRA_SYNC_RST;
      s3_q <= CRA_SYNC_RST;
      lvl_q <= CRA_SYNC_RST;
    end else begin
      s1_q <= {timestamp_capture, counter_clock};
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  // registers
  logic enable_q, hour_fmt_q, match_clr_q;
  logic [1:0] mode_q;
  logic [CRA_NFLAGS-1:0] flags_q, flags_d, flag_set;
  logic [31:0] clock_q, clock_d, alarm_q, stamp_q, prdata_q;
  logic [15:0] comp0_q, comp1_q;
  logic [2:0] mask_sel_q;
  logic tamper_q, tamper_d;

  // APB decode
  logic setup, access, mapped, wr;
  logic hit_ctrl, hit_flags, hit_clock, hit_comp0, hit_comp1;
  logic hit_alarm, hit_mask, hit_stamp, rd_stamp;
  logic [31:0] rd_mux, ctrl_word;

  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign hit_ctrl = (paddr == CRA_OFF_CONTROL_A);
  assign hit_flags = (paddr == CRA_OFF_FLAGS);
  assign hit_clock = (paddr == CRA_OFF_CLOCK);
  assign hit_comp0 = (paddr == CRA_OFF_COMP0);
  assign hit_comp1 = (paddr == CRA_OFF_COMP1);
  assign hit_alarm = (paddr == CRA_OFF_ALARM);
  assign hit_mask = (paddr == CRA_OFF_MASK);
  assign hit_stamp = (paddr == CRA_OFF_STAMP);
  assign mapped = hit_ctrl | hit_flags | hit_clock | hit_comp0 | hit_comp1 |
                  hit_alarm | hit_mask | hit_stamp;
  assign wr = access & pwrite & mapped;
  assign rd_stamp = access & ~pwrite & hit_stamp;

  logic wr_ctrl, wr_flags, wr_alarm, wr_mask, wr_comp0, wr_comp1;
  assign wr_ctrl = wr & hit_ctrl;
  assign wr_flags = wr & hit_flags;
  assign wr_alarm = wr & hit_alarm;
  assign wr_mask = wr & hit_mask;
  assign wr_comp0 = wr & hit_comp0;
  assign wr_comp1 = wr & hit_comp1;

  // zero wait states; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = access & ~mapped;
  assign prdata = prdata_q;

  always_comb begin
    ctrl_word = 32'h0;
    ctrl_word[CRA_EN_BIT] = enable_q;
    ctrl_word[CRA_MODE_LSB +: 2] = mode_q;
    ctrl_word[CRA_HFMT_BIT] = hour_fmt_q;
    ctrl_word[CRA_MCLR_BIT] = match_clr_q;
  end

  assign rd_mux = hit_ctrl ? ctrl_word :
                  hit_flags ? {28'h0, flags_q} :
                  hit_clock ? clock_q :
                  hit_comp0 ? {16'h0, comp0_q} :
                  hit_comp1 ? {16'h0, comp1_q} :
                  hit_alarm ? alarm_q :
                  hit_mask ? {29'h0, mask_sel_q} :
                  hit_stamp ? stamp_q : 32'h0;

  // counter datapath
  logic tick, cal_mode, c16_mode, alarm_hit, clr_hit, cap, wr_clock;
  logic cal_wrap, ovf_step;
  logic [31:0] cal_next, cnt_step, clr_val;
  logic [15:0] cnt16;

  assign tick = rise[0] & enable_q;
  assign cap = rise[1];
  assign cal_mode = (mode_q == CRA_MODE_CAL);
  assign c16_mode = (mode_q == CRA_MODE_C16);
  assign cnt16 = clock_q[15:0];
  assign wr_clock = wr & hit_clock;

  cra_cal_step u_step (
    .cur_val(clock_q),
    .twelve_hour(hour_fmt_q),
    .next_val(cal_next),
    .wrapped(cal_wrap)
  );

  // masked fields drop out of the compare; select 0 or 7 disables it
  logic [31:0] alarm_mask;
  assign alarm_mask = cra_alarm_mask(mask_sel_q);
  assign alarm_hit = ~c16_mode &
                     (((clock_q ^ alarm_q) & alarm_mask) == 32'h0) &
                     (alarm_mask != 32'h0);
  assign clr_hit = tick & alarm_hit & match_clr_q;
  assign clr_val = cal_mode ? cra_cal_zero(hour_fmt_q) : 32'h0;

  assign cnt_step = cal_mode ? cal_next :
                    c16_mode ? {16'h0, cnt16 + 16'h1} : clock_q + 32'h1;
  assign ovf_step = cal_mode ? cal_wrap : c16_mode ? &cnt16 : &clock_q;

  // software write beats a same-cycle tick
  assign clock_d = wr_clock ? pwdata :
                   clr_hit ? clr_val :
                   tick ? cnt_step : clock_q;

  // alarm is checked on the value before this edge's increment
  assign flag_set[CRA_F_OVF] = clr_hit | (tick & ovf_step);
  assign flag_set[CRA_F_ALM] = tick & alarm_hit;
  assign flag_set[CRA_F_CMP0] = tick & c16_mode & (cnt16 == comp0_q);
  assign flag_set[CRA_F_CMP1] = tick & c16_mode & (cnt16 == comp1_q);

  // write one to clear; a same-cycle set wins
  assign flags_d = (flags_q & ~(wr_flags ? pwdata[CRA_NFLAGS-1:0] : {CRA_NFLAGS{1'b0}})) |
                   flag_set;

  assign tamper_d = cap | (tamper_q & ~rd_stamp);
  assign tamper_dma_req = tamper_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_q <= CRA_RST_WORD;
      flags_q <= '0;
      stamp_q <= CRA_RST_WORD;
      tamper_q <= 1'b0;
      prdata_q <= CRA_RST_WORD;
    end else begin
      clock_q <= clock_d;
      flags_q <= flags_d;
      tamper_q <= tamper_d;
      if (cap) begin
        stamp_q <= clock_q;
      end
      if (setup) begin
        prdata_q <= rd_mux;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_q <= 1'b0;
      mode_q <= CRA_MODE_C32;
      hour_fmt_q <= 1'b0;
      match_clr_q <= 1'b0;
    end else if (wr_ctrl) begin
      enable_q <= pwdata[CRA_EN_BIT];
      mode_q <= pwdata[CRA_MODE_LSB +: 2];
      match_clr_q <= pwdata[CRA_MCLR_BIT];
      if (!enable_q) begin
        hour_fmt_q <= pwdata[CRA_HFMT_BIT];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm_q <= CRA_RST_WORD;
      comp0_q <= 16'h0;
      comp1_q <= 16'h0;
      mask_sel_q <= CRA_MASK_RST;
    end else begin
      if (wr_alarm) begin
        alarm_q <= pwdata;
      end
      if (wr_comp0) begin
        comp0_q <= pwdata[15:0];
      end
      if (wr_comp1) begin
        comp1_q <= pwdata[15:0];
      end
      if (wr_mask) begin
        mask_sel_q <= pwdata[2:0];
      end
    end
  end

  // checks
  default clocking cra_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic cal_top;
  assign cal_top = cal_mode & cal_wrap;

  ovf_wrap_a: assert property (
    tick & cal_top & ~clr_hit & ~wr_clock |=>
      flags_q[CRA_F_OVF] && clock_q == cra_cal_zero(hour_fmt_q))
    else $error("calendar top did not wrap with overflow");

  sec_step_a: assert property (
    tick & cal_mode & ~clr_hit & ~wr_clock & (clock_q[5:0] < CRA_SEC_MAX) |=>
      clock_q[5:0] == $past(clock_q[5:0]) + 6'h01)
    else $error("seconds did not advance on tick");

  alarm_flag_a: assert property (
    tick & alarm_hit |=> flags_q[CRA_F_ALM])
    else $error("alarm flag not set after match");

  alarm_cause_a: assert property (
    $rose(flags_q[CRA_F_ALM]) |-> $past(tick) && $past(alarm_hit))
    else $error("alarm flag set without masked match");

  match_clear_a: assert property (
    clr_hit & ~wr_clock |=> clock_q == $past(clr_val))
    else $error("counter not cleared on alarm match");

  clr_both_a: assert property (
    clr_hit |=> flags_q[CRA_F_OVF] & flags_q[CRA_F_ALM])
    else $error("alarm and overflow not set together");

  cmp_flag_a: assert property (
    tick & c16_mode & (cnt16 == comp1_q) |=> flags_q[CRA_F_CMP1])
    else $error("compare flag not set on match");

  hour_lock_a: assert property (
    enable_q |=> $stable(hour_fmt_q))
    else $error("hour format changed while enabled");

  tamper_set_a: assert property (
    cap |=> tamper_dma_req ##0 stamp_q == $past(clock_q))
    else $error("capture did not raise tamper request");

  tamper_drop_a: assert property (
    rd_stamp & ~cap |=> !tamper_dma_req)
    else $error("timestamp read did not drop request");

  tamper_hold_a: assert property (
    tamper_dma_req & ~rd_stamp |=> tamper_dma_req)
    else $error("tamper request dropped without a read");

  cnt_step_a: assert property (
    tick & ~cal_mode & ~c16_mode & ~clr_hit & ~wr_clock |=>
      clock_q == $past(clock_q) + 32'h1)
    else $error("32-bit count did not advance on tick");

  c16_step_a: assert property (
    tick & c16_mode & ~clr_hit & ~wr_clock |=>
      clock_q[31:16] == 16'h0 && clock_q[15:0] == $past(clock_q[15:0]) + 16'h1)
    else $error("16-bit count did not advance on tick");

  cmp0_flag_a: assert property (
    tick & c16_mode & (cnt16 == comp0_q) |=> flags_q[CRA_F_CMP0])
    else $error("compare zero flag not set on match");

  idle_hold_a: assert property (
    ~enable_q & ~wr_clock |=> $stable(clock_q))
    else $error("counter moved while disabled");

  date_base_a: assert property (
    tick & cal_mode & ~wr_clock |=>
      clock_q[CRA_DAY_LSB +: 5] != 5'h00 && clock_q[CRA_MON_LSB +: 4] != 4'h0)
    else $error("day or month stepped to zero");

  hour_range_a: assert property (
    tick & cal_mode & ~hour_fmt_q & ~wr_clock |=>
      clock_q[CRA_HOUR_LSB +: 5] <= CRA_HOUR24_MAX)
    else $error("24-hour field left its range");

  time_range_a: assert property (
    tick & cal_mode & ~wr_clock |=>
      clock_q[5:0] <= CRA_SEC_MAX && clock_q[CRA_MIN_LSB +: 6] <= CRA_SEC_MAX)
    else $error("seconds or minutes left their range");

  year_step_a: assert property (
    tick & cal_mode & ~clr_hit & ~wr_clock & ~cal_wrap |=>
      clock_q[CRA_YEAR_LSB +: 6] >= $past(clock_q[CRA_YEAR_LSB +: 6]))
    else $error("year went back without a wrap");

  flag_clear_a: assert property (
    wr_flags & pwdata[CRA_F_ALM] & ~flag_set[CRA_F_ALM] |=> !flags_q[CRA_F_ALM])
    else $error("alarm flag not cleared by write");

  cal_tick_c: cover property (tick & cal_mode);
  cal_wrap_c: cover property (tick & cal_top);
  alarm_clr_c: cover property (clr_hit);
  tamper_rd_c: cover property (tamper_dma_req ##1 rd_stamp);
  cmp_hit_c: cover property (tick & c16_mode & (cnt16 == comp0_q));

endmodule

`default_nettype wire

/* File: sim/calendar_rtc_alarm_tb_top.sv */
/*
  Self-checking bench for the calendar counter: APB master tasks, an integer
  model of the calendar step, and directed plus pseudo-random scenarios.
  Assumes the design answers with pready and that counter_clock and
  timestamp_capture may be driven slowly compared to pclk.
*/
`timescale 1ns/10ps
`default_nettype none

`define CHK(g, x) begin \
  n_tests++; \
  if ((g) !== (x)) begin \
    err_total++; \
    $display("wrong value at %0t ns: got %h expected %h", $time, (g), (x)); \
  end \
end

module calendar_rtc_alarm_tb_top
  import cra_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, seed, d;
  logic counter_clock, timestamp_capture, tamper_dma_req, er;
  int err_total, n_tests, cyc, v, i, sel;
  int exp_q[$];
  bit w;

  cra_rtc_core i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .counter_clock(counter_clock),
    .timestamp_capture(timestamp_capture), .tamper_dma_req(tamper_dma_req));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 6000) begin
      err_total++;
      end_of_test();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  function automatic int dim(input int mo, input int y);
    if (mo == 2) return (y % 4 == 0) ? 29 : 28;
    if (mo == 4 || mo == 6 || mo == 9 || mo == 11) return 30;
    return 31;
  endfunction

  function automatic int mk(input int s, input int m, input int h, input int dd,
                            input int mo, input int y);
    return s | (m << 6) | (h << 12) | (dd << 17) | (mo << 22) | (y << 26);
  endfunction

  // integer calendar model; 12h hours carry a PM flag above the 4-bit hour
  function automatic int cal_next(input int t, input bit tw, output bit wrap);
    int s, m, h, dd, mo, y, pm;
    bit nd;
    s = t & 63;
    m = (t >> 6) & 63;
    h = (t >> 12) & 31;
    dd = (t >> 17) & 31;
    mo = (t >> 22) & 15;
    y = (t >> 26) & 63;
    pm = tw ? h >> 4 : 0;
    h = tw ? h & 15 : h;
    wrap = 0;
    nd = 0;
    s++;
    if (s == 60) begin
      s = 0;
      m++;
    end
    if (m == 60) begin
      m = 0;
      h++;
      if (tw) begin
        if (h == 13) h = 1;
        if (h == 12) begin
          pm ^= 1;
          nd = (pm == 0);
        end
      end else if (h == 24) begin
        h = 0;
        nd = 1;
      end
    end
    if (nd) begin
      dd++;
      if (dd > dim(mo, y)) begin
        dd = 1;
        mo++;
      end
      if (mo > 12) begin
        mo = 1;
        y++;
      end
      if (y > 63) begin
        y = 0;
        wrap = 1;
      end
    end
    return mk(s, m, h | (pm << 4), dd, mo, y);
  endfunction

  // one transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rdat, output logic rerr);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // no limit here: only the bench timeout ends a wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input int x);
    logic [31:0] rd;
    logic re;
    apb(1'b1, a, 32'(x), rd, re);
  endtask

  task automatic rd_chk(input logic [7:0] a, input int x);
    logic [31:0] rd;
    logic re;
    apb(1'b0, a, 32'h0000_0000, rd, re);
    `CHK(rd, 32'(x))
    `CHK(re, 1'b0)
  endtask

  // pin high and low well past the synchroniser depth; drives the
  // bench signals directly, a task argument copy would never reach them
  task automatic pulse(input bit stamp);
    if (stamp) begin
      timestamp_capture <= 1'b1;
    end else begin
      counter_clock <= 1'b1;
    end
    repeat (6) @(posedge pclk);
    timestamp_capture <= 1'b0;
    counter_clock <= 1'b0;
    repeat (6) @(posedge pclk);
  endtask

  // each pulse stands for one period of the 1 Hz counter clock
  task automatic tick;
    pulse(1'b0);
  endtask

  task automatic cal_case(input int t, input bit tw);
    wr(CRA_OFF_CLOCK, t);
    wr(CRA_OFF_FLAGS, 32'h0000_000F);
    tick();
    exp_q.push_back(cal_next(t, tw, w));
    exp_q.push_back(int'(w));
    rd_chk(CRA_OFF_CLOCK, exp_q.pop_front());
    rd_chk(CRA_OFF_FLAGS, exp_q.pop_front());
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    counter_clock = 1'b0;
    timestamp_capture = 1'b0;
    seed = 32'h553C_7E75;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(CRA_OFF_CONTROL_A, 0);
    rd_chk(CRA_OFF_CLOCK, 0);
    rd_chk(CRA_OFF_FLAGS, 0);
    apb(1'b0, 8'h20, 32'h0000_0000, d, er);
    `CHK({er, d}, 33'h1_0000_0000)
    `CHK(pready, 1'b1)
    $display("test reset done");
    wr(CRA_OFF_CONTROL_A, 32'h0000_0048);
    wr(CRA_OFF_CONTROL_A, 32'h0000_0049);
    wr(CRA_OFF_CONTROL_A, 32'h0000_0009);
    rd_chk(CRA_OFF_CONTROL_A, 32'h0000_0049);
    cal_case(mk(59, 59, 11, 1, 1, 0), 1'b1);
    wr(CRA_OFF_CONTROL_A, 32'h0000_0048);
    wr(CRA_OFF_CONTROL_A, 32'h0000_0008);
    wr(CRA_OFF_CONTROL_A, 32'h0000_0009);
    rd_chk(CRA_OFF_CONTROL_A, 32'h0000_0009);
    $display("test hour format done");
    cal_case(mk(59, 59, 23, 31, 12, 63), 1'b0);
    cal_case(mk(59, 59, 23, 28, 2, 4), 1'b0);
    cal_case(mk(59, 59, 23, 28, 2, 5), 1'b0);
    cal_case(mk(59, 59, 23, 30, 4, 1), 1'b0);
    for (i = 0; i < 8; i++) begin
      seed = lfsr(lfsr(lfsr(seed)));
      v = 1 + int'(seed[23:20]) % 12;
      cal_case(mk(int'(seed[0]) ? 59 : int'(seed[5:0]) % 60, int'(seed[11:6]) % 60,
        int'(seed[16:12]) % 24, dim(v, int'(seed[31:26])) - int'(seed[17]), v,
        int'(seed[31:26])), 1'b0);
    end
    $display("test calendar done");
    v = mk(30, 20, 10, 15, 6, 33);
    wr(CRA_OFF_ALARM, v ^ 32'h8000_0000);
    for (sel = 0; sel < 8; sel++) begin
      wr(CRA_OFF_MASK, sel);
      wr(CRA_OFF_CLOCK, v);
      wr(CRA_OFF_FLAGS, 32'h0000_000F);
      tick();
      rd_chk(CRA_OFF_FLAGS, (sel >= 1 && sel <= 5) ? 2 : 0);
      rd_chk(CRA_OFF_CLOCK, cal_next(v, 1'b0, w));
    end
    wr(CRA_OFF_CONTROL_A, 32'h0000_0089);
    wr(CRA_OFF_ALARM, v);
    wr(CRA_OFF_MASK, 6);
    wr(CRA_OFF_CLOCK, v);
    wr(CRA_OFF_FLAGS, 32'h0000_000F);
    tick();
    rd_chk(CRA_OFF_CLOCK, 32'h0042_0000);
    rd_chk(CRA_OFF_FLAGS, 3);
    $display("test alarm done");
    wr(CRA_OFF_CONTROL_A, 32'h0000_0005);
    wr(CRA_OFF_COMP0, 32'h0000_0010);
    wr(CRA_OFF_COMP1, 32'h0000_0011);
    wr(CRA_OFF_CLOCK, 32'h0000_0010);
    wr(CRA_OFF_FLAGS, 32'h0000_000F);
    tick();
    rd_chk(CRA_OFF_FLAGS, 4);
    tick();
    rd_chk(CRA_OFF_FLAGS, 32'h0000_000C);
    rd_chk(CRA_OFF_CLOCK, 32'h0000_0012);
    wr(CRA_OFF_CLOCK, 32'h0000_FFFF);
    tick();
    rd_chk(CRA_OFF_CLOCK, 0);
    rd_chk(CRA_OFF_FLAGS, 32'h0000_000D);
    wr(CRA_OFF_CONTROL_A, 32'h0000_0001);
    wr(CRA_OFF_CLOCK, 32'hFFFF_FFFF);
    wr(CRA_OFF_FLAGS, 32'h0000_000F);
    tick();
    rd_chk(CRA_OFF_CLOCK, 0);
    rd_chk(CRA_OFF_FLAGS, 1);
    $display("test counter modes done");
    wr(CRA_OFF_CONTROL_A, 32'h0000_0008);
    wr(CRA_OFF_CLOCK, v);
    `CHK(tamper_dma_req, 1'b0)
    pulse(1'b1);
    `CHK(tamper_dma_req, 1'b1)
    rd_chk(CRA_OFF_STAMP, v);
    @(posedge pclk);
    `CHK(tamper_dma_req, 1'b0)
    $display("test timestamp done");
    end_of_test();
  end
endmodule

`default_nettype wire
